// File: hw/vic_pkg.sv
// Constants shared by the interrupt controller files
package vic_pkg;
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 32;
    localparam int          NSRC        = 32;
    localparam int          PRIO_W      = 4;
    localparam int          IDX_W       = 5;
    localparam int          EV_W        = 3;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_IRQ_ST  = 12'h000;
    localparam logic [11:0] OFF_FAST_ST = 12'h004;
    localparam logic [11:0] OFF_RAW     = 12'h008;
    localparam logic [11:0] OFF_CLASS   = 12'h00c;
    localparam logic [11:0] OFF_EN      = 12'h010;
    localparam logic [11:0] OFF_VECT    = 12'h014;
    localparam logic [11:0] OFF_DEF     = 12'h018;
    localparam logic [11:0] OFF_EV_ST   = 12'h01c;
    localparam logic [11:0] OFF_EV_MASK = 12'h020;
    localparam logic [11:0] OFF_RISE0   = 12'h024;
    localparam logic [11:0] OFF_FALL0   = 12'h028;
    localparam logic [11:0] OFF_RISE2   = 12'h02c;
    localparam logic [11:0] OFF_FALL2   = 12'h030;
    localparam logic [11:0] OFF_GST0    = 12'h034;
    localparam logic [11:0] OFF_GST2    = 12'h038;
    localparam logic [11:0] OFF_PRIO    = 12'h100;
    localparam logic [11:0] OFF_VADDR   = 12'h200;
    // Event status bit positions
    localparam int          EV_FAST     = 0;
    localparam int          EV_NORM     = 1;
    localparam int          EV_GPIO     = 2;
    // Reset values and bus response codes
    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam logic [3:0]  RST_PRIO    = 4'hf;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Bus channel states, Gray coded along idle, take, answer
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_TAKE = 2'h1,
        ST_RESP = 2'h3
    } bus_st_t;
endpackage : vic_pkg

// File: hw/edge_if.sv
// Carrier between the controller and one port edge detector
`timescale 1ns/1ps
interface edge_if #(parameter int W = 32);
    logic [W-1:0] pins;
    logic [W-1:0] rise_en;
    logic [W-1:0] fall_en;
    logic [W-1:0] clr;
    logic [W-1:0] status;
    modport ctrl (output pins, rise_en, fall_en, clr, input status);
    modport det  (input pins, rise_en, fall_en, clr, output status);
endinterface : edge_if

// File: hw/port_edge_detect.sv
// Per-pin rising/falling edge capture with sticky status
`timescale 1ns/1ps
module port_edge_detect
    import vic_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic i_clk_sys,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    edge_if.det       e
);
    logic [W-1:0] prev_q;
    logic         armed_q;
    logic [W-1:0] stat_q;
    logic [W-1:0] hit;

    // Edge seen only once a previous sample exists, avoiding a false hit
    assign hit = armed_q ? ((e.pins & ~prev_q & e.rise_en) |
                            (~e.pins & prev_q & e.fall_en)) : '0;

    // Sample history
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            prev_q  <= '0;
            armed_q <= 1'b0;
        end else if (i_ce) begin
            prev_q  <= e.pins;
            armed_q <= 1'b1;
        end
    end

    // Sticky status: a new edge wins over a clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            stat_q <= '0;
        end else if (i_ce) begin
            stat_q <= (stat_q & ~e.clr) | hit;
        end
    end

    assign e.status = stat_q;

    edge_set_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_resetn) (i_ce && |hit) |=>
        ((stat_q & $past(hit)) == $past(hit)))
        else $error("edge not captured");
endmodule : port_edge_detect

// File: hw/prio_select.sv
// Picks the most urgent pending normal source, lowest channel on a tie
`timescale 1ns/1ps
module prio_select
    import vic_pkg::*;
#(
    parameter int N = NSRC
) (
    input  wire logic [N-1:0]             i_pend,
    input  wire logic [N-1:0][PRIO_W-1:0] i_prio,
    output logic                          o_valid,
    output logic [IDX_W-1:0]              o_idx
);
    logic [PRIO_W-1:0] best;

    // Strict compare while scanning upward keeps the lower channel
    always_comb begin
        o_valid = 1'b0;
        o_idx   = '0;
        best    = '1;
        for (int i = 0; i < N; i++) begin
            if (i_pend[i] && (!o_valid || i_prio[i] < best)) begin
                o_valid = 1'b1;
                o_idx   = IDX_W'(i);
                best    = i_prio[i];
            end
        end
    end
endmodule : prio_select

// File: hw/vectored_irq_controller.sv
// Vectored interrupt controller with AXI4-Lite register access
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module vectored_irq_controller
    import vic_pkg::*;
#(
    parameter int N_SRC   = NSRC,
    parameter int EXT3_CH = 17
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_resetn,
    input  wire logic              i_ce,
    input  wire logic [N_SRC-1:0]  i_irq_src,
    input  wire logic [31:0]       i_gpio_port_zero,
    input  wire logic [31:0]       i_gpio_port_two,
    output logic                   o_fast_irq_line,
    output logic                   o_normal_irq,
    output logic                   o_irq,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready
);
    // Parameter check
    if (N_SRC < 1 || N_SRC > NSRC || EXT3_CH >= N_SRC) begin : g_chk
        $error("vectored_irq_controller: bad N_SRC or EXT3_CH");
    end

    // Configuration
    logic [N_SRC-1:0]             class_q;
    logic [N_SRC-1:0]             en_q;
    logic [N_SRC-1:0][PRIO_W-1:0] prio_q;
    logic [31:0]                  vaddr_q [N_SRC];
    logic [31:0]                  def_q;
    logic [EV_W-1:0]              ev_mask_q;
    logic [31:0]                  rise0_q, fall0_q, rise2_q, fall2_q;
    // Status
    logic [N_SRC-1:0]             fast_st_q;
    logic [N_SRC-1:0]             irq_st_q;
    logic [31:0]                  vect_q;
    logic [EV_W-1:0]              ev_st_q;
    logic                         gpio_any_q;
    // Bus
    bus_st_t                      wr_st_q, rd_st_q;
    logic                         wr_fire, rd_fire;
    logic [31:0]                  rd_word;
    logic                         rd_ok;
    // Datapath
    logic [N_SRC-1:0]             src_m, fast_act, norm_act;
    logic                         sel_valid;
    logic [IDX_W-1:0]             sel_idx;
    logic                         gpio_any;
    logic [EV_W-1:0]              ev, ev_next;

    edge_if #(.W(32)) p0 ();
    edge_if #(.W(32)) p2 ();

    // True if addr falls in the first N_SRC words of the 32-word table at base
    function automatic logic in_tab(input logic [ADDR_W-1:0] a,
                                    input logic [11:0] base);
        in_tab = (a[11:7] == base[11:7]) && (32'(a[6:2]) < N_SRC);
    endfunction : in_tab

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++) begin
            merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction : merge

    // Writable or readable word at this offset
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a[11:2] <= OFF_GST2[11:2]) || in_tab(a, OFF_PRIO) ||
                 in_tab(a, OFF_VADDR);
    endfunction : mapped

    // Port pins feed both edge detectors
    assign p0.pins    = i_gpio_port_zero;
    assign p0.rise_en = rise0_q;
    assign p0.fall_en = fall0_q;
    assign p0.clr     = (wr_fire && i_awaddr == OFF_GST0) ? i_wdata : '0;
    assign p2.pins    = i_gpio_port_two;
    assign p2.rise_en = rise2_q;
    assign p2.fall_en = fall2_q;
    assign p2.clr     = (wr_fire && i_awaddr == OFF_GST2) ? i_wdata : '0;

    port_edge_detect #(.W(32)) u_edge0 (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .e         (p0)
    );
    port_edge_detect #(.W(32)) u_edge2 (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .e         (p2)
    );

    // Port edge status is ORed onto the EXT3_CH line together with that channel's own request
    assign gpio_any = |p0.status || |p2.status;
    always_comb begin
        src_m          = i_irq_src;
        src_m[EXT3_CH] = i_irq_src[EXT3_CH] | gpio_any;
    end

    // Classification splits enabled requests into two classes
    assign fast_act = src_m & en_q & class_q;
    assign norm_act = src_m & en_q & ~class_q;

    prio_select #(.N(N_SRC)) u_sel (
        .i_pend  (norm_act),
        .i_prio  (prio_q),
        .o_valid (sel_valid),
        .o_idx   (sel_idx)
    );

    // Core lines and status words, registered so outputs are glitch free
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_fast_irq_line <= 1'b0;
            o_normal_irq    <= 1'b0;
            fast_st_q       <= '0;
            irq_st_q        <= '0;
            vect_q          <= RST_ZERO;
        end else if (i_ce) begin
            o_fast_irq_line <= |fast_act;
            o_normal_irq    <= |norm_act;
            fast_st_q       <= fast_act;
            irq_st_q        <= norm_act;
            vect_q <= sel_valid ? vaddr_q[sel_idx] : def_q;
        end
    end

    // Block events: fast or normal line rising, port edge status going from none to some
    always_comb begin
        ev          = '0;
        ev[EV_FAST] = |fast_act && !o_fast_irq_line;
        ev[EV_NORM] = |norm_act && !o_normal_irq;
        ev[EV_GPIO] = gpio_any && !gpio_any_q;
        ev_next     = ev_st_q | ev;
        if (rd_fire && i_araddr == OFF_EV_ST) begin
            ev_next = ev; // Read clears, but a fresh event survives
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ev_st_q    <= '0;
            gpio_any_q <= 1'b0;
            o_irq      <= 1'b0;
        end else if (i_ce) begin
            ev_st_q    <= ev_next;
            gpio_any_q <= gpio_any;
            o_irq      <= |(ev_next & ev_mask_q);
        end
    end

    // Write channel: address and data are taken together
    assign wr_fire = (wr_st_q == ST_TAKE);
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            wr_st_q   <= ST_IDLE;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
        end else if (i_ce) begin
            case (wr_st_q)
                ST_IDLE: begin
                    if (i_awvalid && i_wvalid) begin
                        o_awready <= 1'b1;
                        o_wready  <= 1'b1;
                        wr_st_q   <= ST_TAKE;
                    end
                end
                ST_TAKE: begin
                    o_awready <= 1'b0;
                    o_wready  <= 1'b0;
                    o_bvalid  <= 1'b1;
                    o_bresp   <= mapped(i_awaddr) ? RESP_OKAY : RESP_SLVERR;
                    wr_st_q   <= ST_RESP;
                end
                ST_RESP: begin
                    if (i_bready) begin
                        o_bvalid <= 1'b0;
                        wr_st_q  <= ST_IDLE;
                    end
                end
                default: wr_st_q <= ST_IDLE;
            endcase
        end
    end

    // Configuration writes take effect on the next cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            class_q   <= '0;
            en_q      <= '0;
            def_q     <= RST_ZERO;
            ev_mask_q <= '0;
            rise0_q   <= RST_ZERO;
            fall0_q   <= RST_ZERO;
            rise2_q   <= RST_ZERO;
            fall2_q   <= RST_ZERO;
            for (int i = 0; i < N_SRC; i++) begin
                prio_q[i] <= RST_PRIO;
            end
        end else if (i_ce && wr_fire) begin
            case (i_awaddr)
                OFF_CLASS: class_q <= N_SRC'(merge(32'(class_q), i_wdata,
                                                   i_wstrb));
                OFF_EN:    en_q <= N_SRC'(merge(32'(en_q), i_wdata, i_wstrb));
                OFF_DEF:   def_q   <= merge(def_q, i_wdata, i_wstrb);
                OFF_EV_MASK: begin
                    if (i_wstrb[0]) begin
                        ev_mask_q <= i_wdata[EV_W-1:0];
                    end
                end
                OFF_RISE0: rise0_q <= merge(rise0_q, i_wdata, i_wstrb);
                OFF_FALL0: fall0_q <= merge(fall0_q, i_wdata, i_wstrb);
                OFF_RISE2: rise2_q <= merge(rise2_q, i_wdata, i_wstrb);
                OFF_FALL2: fall2_q <= merge(fall2_q, i_wdata, i_wstrb);
                default: begin
                    if (in_tab(i_awaddr, OFF_PRIO) && i_wstrb[0]) begin
                        prio_q[i_awaddr[6:2]] <= i_wdata[PRIO_W-1:0];
                    end
                end
            endcase
        end
    end

    // Handler address table, kept apart since it has no reset
    always_ff @(posedge i_clk_sys) begin
        if (i_ce && wr_fire && in_tab(i_awaddr, OFF_VADDR)) begin
            vaddr_q[i_awaddr[6:2]] <= merge(vaddr_q[i_awaddr[6:2]],
                                            i_wdata, i_wstrb);
        end
    end

    // Read data selection
    always_comb begin
        rd_word = RST_ZERO;
        rd_ok   = 1'b1;
        case (i_araddr)
            OFF_IRQ_ST:  rd_word = 32'(irq_st_q);
            OFF_FAST_ST: rd_word = 32'(fast_st_q);
            OFF_RAW:     rd_word = 32'(src_m);
            OFF_CLASS:   rd_word = 32'(class_q);
            OFF_EN:      rd_word = 32'(en_q);
            OFF_VECT:    rd_word = vect_q;
            OFF_DEF:     rd_word = def_q;
            OFF_EV_ST:   rd_word = 32'(ev_st_q);
            OFF_EV_MASK: rd_word = 32'(ev_mask_q);
            OFF_RISE0:   rd_word = rise0_q;
            OFF_FALL0:   rd_word = fall0_q;
            OFF_RISE2:   rd_word = rise2_q;
            OFF_FALL2:   rd_word = fall2_q;
            OFF_GST0:    rd_word = p0.status;
            OFF_GST2:    rd_word = p2.status;
            default: begin
                if (in_tab(i_araddr, OFF_PRIO)) begin
                    rd_word = 32'(prio_q[i_araddr[6:2]]);
                end else if (in_tab(i_araddr, OFF_VADDR)) begin
                    rd_word = vaddr_q[i_araddr[6:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // Read channel
    assign rd_fire = (rd_st_q == ST_TAKE);
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            rd_st_q   <= ST_IDLE;
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= RST_ZERO;
            o_rresp   <= RESP_OKAY;
        end else if (i_ce) begin
            case (rd_st_q)
                ST_IDLE: begin
                    if (i_arvalid) begin
                        o_arready <= 1'b1;
                        rd_st_q   <= ST_TAKE;
                    end
                end
                ST_TAKE: begin
                    o_arready <= 1'b0;
                    o_rvalid  <= 1'b1;
                    o_rdata   <= rd_word;
                    o_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
                    rd_st_q   <= ST_RESP;
                end
                ST_RESP: begin
                    if (i_rready) begin
                        o_rvalid <= 1'b0;
                        rd_st_q  <= ST_IDLE;
                    end
                end
                default: rd_st_q <= ST_IDLE;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    logic tie_ok;
    always_comb begin
        tie_ok = 1'b1;
        for (int j = 0; j < N_SRC; j++) begin
            if (norm_act[j] && (prio_q[j] < prio_q[sel_idx] ||
                (prio_q[j] == prio_q[sel_idx] && IDX_W'(j) < sel_idx))) begin
                tie_ok = 1'b0;
            end
        end
    end

    sequence all_off_s;
        i_ce && (en_q == '0);
    endsequence

    fast_or_a: assert property (i_ce |=> o_fast_irq_line ==
        $past(|fast_act)) else $error("fast line mismatch");
    fast_prec_a: assert property (i_ce && |(src_m & en_q & class_q) &&
        !(|norm_act) |=> !o_normal_irq) else $error("fast leaked to normal");
    fast_stat_a: assert property (i_ce |=> fast_st_q ==
        $past(fast_act)) else $error("fast status wrong");
    norm_or_a: assert property (i_ce |=> o_normal_irq ==
        $past(|norm_act)) else $error("normal line mismatch");
    tie_pick_a: assert property (sel_valid |-> tie_ok &&
        norm_act[sel_idx]) else $error("wrong source selected");
    vect_addr_a: assert property (i_ce && sel_valid |=> vect_q ==
        $past(vaddr_q[sel_idx])) else $error("vector address wrong");
    class_write_a: assert property (i_ce && wr_fire &&
        i_awaddr == OFF_CLASS && i_wstrb == 4'hf |=>
        class_q == $past(N_SRC'(i_wdata))) else $error("class not applied");
    dis_quiet_a: assert property (all_off_s |=>
        !o_fast_irq_line && !o_normal_irq) else $error("disabled irq out");
    ext3_merge_a: assert property (gpio_any |->
        src_m[EXT3_CH]) else $error("port edge not merged");
    rd_clear_a: assert property (i_ce && rd_fire &&
        i_araddr == OFF_EV_ST |=> ev_st_q == $past(ev))
        else $error("event status not cleared");
endmodule : vectored_irq_controller

// File: dv/periph_bank.sv
// Peripheral side model: each peripheral folds its flags into one line
`timescale 1ns/1ps
module periph_bank (
    input  wire logic [31:0] i_flag_a,
    input  wire logic [31:0] i_flag_b,
    output logic [31:0]      o_req
);
    // Two internal flags per peripheral share a single request line
    assign o_req = i_flag_a | i_flag_b;
endmodule : periph_bank

// File: dv/tb_top.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module tb_top;
    import vic_pkg::*;
    logic        clk, rstn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic        fast, norm, irq, awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, fa, fb, src, gz, gt, cls, en, d, dv;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  wstrb;
    logic [31:0] vec [32];
    logic [3:0]  pr [32];
    int          fails, total_checks, cyc;

    periph_bank periph_bank_i (.i_flag_a(fa), .i_flag_b(fb), .o_req(src));
    vectored_irq_controller vectored_irq_controller_i (
        .i_clk_sys(clk), .i_resetn(rstn), .i_ce(ce), .i_irq_src(src),
        .i_gpio_port_zero(gz), .i_gpio_port_two(gt),
        .o_fast_irq_line(fast), .o_normal_irq(norm), .o_irq(irq),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready));

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Watchdog: a hung handshake ends the run as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Write: address and data offered together, held until taken
    task automatic wr(input logic [11:0] a, input logic [31:0] dd);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= dd;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Each channel is released only when its own ready is seen
        do begin
            @(posedge clk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // Most urgent pending normal source; strict compare keeps lowest on tie
    function automatic logic [31:0] exp_vec(input logic [31:0] p);
        int b;
        int bp;
        b = -1;
        bp = 16;
        for (int i = 0; i < 32; i++)
            if (p[i] && pr[i] < bp) begin
                b = i;
                bp = pr[i];
            end
        return (b < 0) ? dv : vec[b];
    endfunction : exp_vec

    initial begin
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        {fa, fb, gz, gt} = '0;
        ce = 1'b1;
        wstrb = 4'hf;
        d = $urandom(73);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(OFF_CLASS);
        chk("class_reset", RST_ZERO, d);
        rd(OFF_PRIO + 12'h004);
        chk("prio_reset", {28'h0, RST_PRIO}, d);
        rd(12'h300);
        chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(OFF_IRQ_ST, 32'hffff_ffff);
        chk("ro_write_resp", {30'h0, RESP_OKAY}, {30'h0, r});
        dv = $urandom;
        wr(OFF_DEF, dv);
        for (int i = 0; i < 32; i++) begin
            vec[i] = $urandom;
            wr(OFF_VADDR + 12'(4 * i), vec[i]);
        end
        // Pass 0: equal priorities; pass 1: all fast; then random
        for (int t = 0; t < 24; t++) begin
            cls = (t == 0) ? '0 : (t == 1) ? '1 : $urandom;
            en = (t < 2) ? '1 : $urandom;
            for (int i = 0; i < 32; i++) begin
                pr[i] = (t == 0) ? 4'h5 : 4'($urandom);
                wr(OFF_PRIO + 12'(4 * i), {28'h0, pr[i]});
            end
            wr(OFF_CLASS, cls);
            wr(OFF_EN, en);
            fa <= (t == 0) ? 32'h0000_0a00 : $urandom;
            fb <= (t < 2) ? 32'h0 : $urandom & $urandom;
            repeat (3) @(posedge clk);
            chk("fast_line", 32'(|(src & en & cls)), 32'(fast));
            chk("norm_line", 32'(|(src & en & ~cls)), 32'(norm));
            chk("masked_irq", 32'h0, {31'h0, irq});
            rd(OFF_FAST_ST);
            chk("fast_status", src & en & cls, d);
            rd(OFF_IRQ_ST);
            chk("norm_status", src & en & ~cls, d);
            rd(OFF_VECT);
            chk("vector", exp_vec(src & en & ~cls), d);
        end
        // Event interrupt: clear, unmask, raise a fast request, read clears
        fa <= 32'h0;
        fb <= 32'h0;
        wr(OFF_CLASS, 32'hffff_ffff);
        wr(OFF_EN, 32'hffff_ffff);
        rd(OFF_EV_ST);
        wr(OFF_EV_MASK, 32'h1);
        chk("irq_clear", 32'h0, {31'h0, irq});
        fa <= 32'h0000_0001;
        repeat (4) @(posedge clk);
        chk("irq_raise", 32'h1, {31'h0, irq});
        rd(OFF_EV_ST);
        chk("event_fast", 32'h1, d & 32'h1);
        repeat (2) @(posedge clk);
        chk("irq_read_clr", 32'h0, {31'h0, irq});
        // Port edges merge into the external pin channel
        fa <= 32'h0;
        wr(OFF_CLASS, 32'h0);
        wr(OFF_EN, 32'h0002_0000);
        wr(OFF_RISE0, 32'h0000_0008);
        wr(OFF_FALL2, 32'h0000_0020);
        gz <= 32'h0000_0008;
        gt <= 32'h0000_0020;
        repeat (3) @(posedge clk);
        rd(OFF_GST0);
        chk("rise_gpio_port_zero", 32'h8, d);
        rd(OFF_GST2);
        chk("rise_gpio_port_two_off", 32'h0, d);
        chk("merge_line", 32'h1, {31'h0, norm});
        rd(OFF_VECT);
        chk("merge_vector", vec[17], d);
        rd(OFF_EV_ST);
        chk("event_norm_port", 32'h6, d);
        wr(OFF_GST0, 32'h0000_0008);
        gt <= 32'h0;
        repeat (3) @(posedge clk);
        rd(OFF_GST2);
        chk("fall_gpio_port_two", 32'h20, d);
        rd(OFF_GST0);
        chk("w1c_gpio_port_zero", 32'h0, d);
        wr(OFF_GST2, 32'h0000_0020);
        repeat (3) @(posedge clk);
        chk("merge_idle", 32'h0, {31'h0, norm});
        // Clock enable low freezes the core lines, high lets them follow
        ce <= 1'b0;
        fa <= 32'h0002_0000;
        repeat (3) @(posedge clk);
        chk("ce_freeze", 32'h0, {31'h0, norm});
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        chk("ce_run", 32'h1, {31'h0, norm});
        wrap_up();
    end
endmodule : tb_top
